/* bench/host_spi_model.sv */
// host controller model driving the serial command port
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
	// bench clock, pins change on its falling edge
	input wire logic clk,
	// serial command pins towards the device
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	// lanes coming back
	input wire logic so_first,
	input wire logic so_first_oe,
	input wire logic so_second_oe
);
	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	// link clock stands still low between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end

	// ------------------------------------------------------------
	// one frame
	// ------------------------------------------------------------
	// 20-bit word msb first; extra > 0 sends leading ones first,
	// extra < 0 cuts the frame short; first 8 lane bits come back
	task automatic xfer(input logic [19:0] word, input int extra,
		output logic [7:0] rd, output logic oe1, output logic oe2);
		int k;
		k = 0;
		rd = 8'h00;
		oe1 = 1'b0;
		oe2 = 1'b0;
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = 19 + extra; i >= 0; i--) begin
			sdi = (i > 19) ? 1'b1 : word[i];
			repeat (16) @(negedge clk);
			if (k == 0) begin
				oe1 = so_first_oe;
				oe2 = so_second_oe;
			end
			if (k < 8) rd[7 - k] = so_first;
			sclk = 1'b1;
			repeat (16) @(negedge clk);
			sclk = 1'b0;
			k++;
		end
		repeat (16) @(negedge clk);
		cs_n = 1'b1;
		// released data line: show the inverse, never the last bit
		sdi = ~sdi;
		repeat (10) @(negedge clk);
	endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the converter configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb
	import cfg_pkg::*;
();
	typedef struct packed {
		logic [3:0] cmd;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] exp;
	} row_t;
	logic MCLK = 1'b0;
	logic RESET_N = 1'b0;
	wire logic CS_N, SCLK, SDI, SO1, SO1_OE, SO2, SO2_OE;
	wire logic CONV_ON, ANA_ON, STBY, FPD, LANE, CODING, REFSRC, RANGE, MODE;
	wire logic [8:0] TRIM1, TRIM2;
	int n_fail = 0;
	int total_checks = 0;
	logic [7:0] rd;
	logic o1, o2;
	// single frame op then a readback of the same address
	row_t rows [18] = '{
		'{CMD_WRITE, 8'h04, 8'hFF, 8'h00}, // locked
		'{CMD_WRITE, 8'h05, 8'hFF, 8'h0F},
		'{CMD_WRITE, 8'h05, 8'h09, 8'h09},
		'{CMD_WRITE, 8'h04, 8'hFF, 8'h06},
		'{CMD_CLEAR_MASKED, 8'h04, 8'h02, 8'h04},
		'{CMD_WRITE, 8'h0D, 8'hFF, 8'h01},
		'{CMD_WRITE, 8'h11, 8'h01, 8'h01},
		'{CMD_WRITE, 8'h20, 8'hFF, 8'h01},
		'{CMD_WRITE, 8'h24, 8'hFF, 8'hFF},
		'{CMD_WRITE, 8'h25, 8'hFF, 8'h01},
		'{CMD_WRITE, 8'h26, 8'h5A, 8'h5A},
		'{CMD_WRITE, 8'h27, 8'hFE, 8'h00},
		'{CMD_SET_MASKED, 8'h27, 8'h01, 8'h01},
		'{CMD_WRITE, 8'h28, 8'hFF, 8'h03},
		'{CMD_CLEAR_MASKED, 8'h28, 8'h01, 8'h02},
		'{CMD_SET_MASKED, 8'h28, 8'h01, 8'h03},
		'{4'h7, 8'h28, 8'h00, 8'h03}, // undefined code idles
		'{CMD_WRITE, 8'h30, 8'hFF, 8'h00} // unmapped address
	};

	// ------------------------------------------------------------
	// clock, device and host
	// ------------------------------------------------------------
	always #2.5 MCLK = ~MCLK;

	adc_config_bank adc_config_bank_i (.MCLK(MCLK), .RESET_N(RESET_N),
		.CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SERIAL_OUT_FIRST(SO1),
		.SERIAL_OUT_FIRST_OE(SO1_OE), .SERIAL_OUT_SECOND(SO2),
		.SERIAL_OUT_SECOND_OE(SO2_OE), .CONVERTER_POWER_ON(CONV_ON),
		.ANALOG_POWER_ON(ANA_ON), .STANDBY_BIT(STBY),
		.FULL_POWERDOWN_BIT(FPD), .LANE_SELECT_BIT(LANE),
		.RESULT_CODING_BIT(CODING), .REFERENCE_SOURCE_BIT(REFSRC),
		.RANGE_SELECT_BIT(RANGE), .INPUT_MODE_BIT(MODE),
		.REF_TRIM_CODE_FIRST(TRIM1), .REF_TRIM_CODE_SECOND(TRIM2));

	host_spi_model host_spi_model_i (.clk(MCLK), .cs_n(CS_N), .sclk(SCLK),
		.sdi(SDI), .so_first(SO1), .so_first_oe(SO1_OE),
		.so_second_oe(SO2_OE));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic op(input logic [3:0] c, input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] r;
		logic x, y;
		host_spi_model_i.xfer({c, a, d}, 0, r, x, y);
	endtask

	// read needs two frames: request, then capture on the first lane
	task automatic rdreg(input logic [7:0] a, output logic [7:0] v,
		output logic oe1, output logic oe2);
		op(CMD_READ, a, 8'h00);
		host_spi_model_i.xfer({CMD_IDLE, 16'h0000}, 0, v, oe1, oe2);
	endtask

	// power and field outputs in one vector
	task automatic chk_pwr(input logic [3:0] exp);
		chk(9'({STBY, FPD, CONV_ON, ANA_ON}), 9'(exp));
	endtask

	task automatic final_report;
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// cut a hang short well past the expected run time
	initial begin
		#450000;
		n_fail++;
		final_report;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(negedge MCLK);
		RESET_N = 1'b1;
		repeat (4) @(negedge MCLK);
		chk_pwr(4'h3);
		chk(9'({LANE, CODING, REFSRC, RANGE, MODE, SO1_OE, SO2}), 9'h000);
		chk(TRIM1 | TRIM2, 9'h000);
		for (int i = 0; i < NUM_REGS; i++) begin
			rdreg(REG_OFFSET[i], rd, o1, o2);
			chk(9'(rd), 9'h000);
		end
		chk(9'({o1, o2}), 9'h003); // both lanes driven
		// table of ordinary cases
		for (int i = 0; i < 18; i++) begin
			op(rows[i].cmd, rows[i].addr, rows[i].data);
			rdreg(rows[i].addr, rd, o1, o2);
			chk(9'(rd), 9'(rows[i].exp));
		end
		chk(9'({o1, o2}), 9'h002); // first lane only
		chk_pwr(4'h9); // standby stops converters only
		chk(9'({LANE, CODING, REFSRC, RANGE, MODE}), 9'h01F);
		chk(TRIM1, 9'h1FF);
		chk(TRIM2, 9'h15A);
		// full power-down and back
		op(CMD_WRITE, 8'h04, 8'h02);
		chk_pwr(4'h4);
		// register traffic only: no conversion follows, so no settling wait
		op(CMD_WRITE, 8'h04, 8'h00);
		chk_pwr(4'h3);
		// relocked key blocks set on the power register
		op(CMD_WRITE, 8'h05, 8'h00);
		op(CMD_SET_MASKED, 8'h04, 8'h06);
		chk_pwr(4'h3);
		// a 19-bit frame is dropped, a 24-bit one uses its last 20
		host_spi_model_i.xfer({CMD_WRITE, 8'h0D, 8'h00}, -1, rd, o1, o2);
		chk(9'(LANE), 9'h001);
		host_spi_model_i.xfer({CMD_WRITE, 8'h11, 8'h00}, 4, rd, o1, o2);
		chk(9'(CODING), 9'h000);
		op(CMD_WRITE, 8'h26, 8'hFF);
		chk(TRIM2, 9'h1FF);
		// back-to-back reads: each frame returns the previous request
		op(CMD_READ, 8'h24, 8'h00);
		host_spi_model_i.xfer({CMD_READ, 8'h25, 8'h00}, 0, rd, o1, o2);
		chk(9'(rd), 9'h0FF);
		host_spi_model_i.xfer({CMD_IDLE, 16'h0000}, 0, rd, o1, o2);
		chk(9'(rd), 9'h001);
		// second reset in mid-run clears every configuration register at once
		RESET_N = 1'b0;
		#1;
		chk(9'({LANE, REFSRC, RANGE, MODE}), 9'h000);
		chk(TRIM1 | TRIM2, 9'h000);
		repeat (16) @(negedge MCLK);
		RESET_N = 1'b1;
		repeat (4) @(negedge MCLK);
		// the first trim held all ones before the reset
		rdreg(8'h24, rd, o1, o2);
		chk(9'(rd), 9'h000);
		final_report;
	end
endmodule
`default_nettype wire

/* pkg/cfg_pkg.sv */
// constants of the converter configuration bank and its serial port
// Operation
// [RQ1] standby bit powers down converters and oscillator only; clearing restores them
// [RQ2] full power-down bit stops everything but serial port and I/O
// [RQ3] power control writes accepted only after key field holds 1001
// [RQ4] lane select bit: 0 both lanes, 1 both channels on first lane
// [RQ5] result coding bit: 0 straight binary, 1 two's complement
// [RQ6] reference source bit: 0 external reference, 1 internal reference
// [RQ7] first trim code low eight bits come from first low trim register
// [RQ8] first high trim bit 0 is trim MSB; other bits reserved
// [RQ9] host programs first trim code 0x1FF for 2.5 V reference
// [RQ10] second trim code built from second low and high registers
// [RQ11] host programs second trim code 0x1FF for 2.5 V reference
// [RQ12] range bit: 0 full scale to reference, 1 to twice reference
// [RQ13] input mode bit: 0 single-ended, 1 pseudo-differential
// [RQ14] every configuration register resets to zero
// [RQ15] commands: 1 write, 2 read, 3 set masked, 4 clear masked, others idle
// [RQ16] last 20 bits decoded on chip select rise; shorter frames dropped
// [RQ17] read data appears as first eight bits on first lane next frame
// [RQ18] host waits 1 ms or 3 ms after leaving full power-down; the bench sends its next frames with no wait
// [RQ19] reserved bits read zero; locked power control writes ignored
// [RQ20] set and clear touch only masked writable bits
package cfg_pkg;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h14;
	localparam int CMD_MSB = 19;
	localparam int CMD_LSB = 16;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_WRITE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;
	localparam logic [3:0] CMD_SET_MASKED = 4'h3;
	localparam logic [3:0] CMD_CLEAR_MASKED = 4'h4;

	// ------------------------------------------------------------
	// register map, index order
	// ------------------------------------------------------------
	localparam int NUM_REGS = 10;
	localparam logic [3:0] IDX_POWER_CONTROL = 4'h0;
	localparam logic [3:0] IDX_UNLOCK_KEY = 4'h1;
	localparam logic [3:0] IDX_LANE_SELECT = 4'h2;
	localparam logic [3:0] IDX_FORMAT_SELECT = 4'h3;
	localparam logic [3:0] IDX_REF_SOURCE = 4'h4;
	localparam logic [3:0] IDX_TRIM_FIRST_LOW = 4'h5;
	localparam logic [3:0] IDX_TRIM_FIRST_HIGH = 4'h6;
	localparam logic [3:0] IDX_TRIM_SECOND_LOW = 4'h7;
	localparam logic [3:0] IDX_TRIM_SECOND_HIGH = 4'h8;
	localparam logic [3:0] IDX_INPUT_SETUP = 4'h9;
	localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{8'h04, 8'h05, 8'h0D,
		8'h11, 8'h20, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
	localparam logic [7:0] WRITE_MASK [NUM_REGS] = '{8'h06, 8'h0F, 8'h01,
		8'h01, 8'h01, 8'hFF, 8'h01, 8'hFF, 8'h01, 8'h03};
	localparam logic [7:0] REG_RESET = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int STANDBY_POS = 2;
	localparam int FULL_POWERDOWN_POS = 1;
	localparam int UNLOCK_KEY_MSB = 3;
	localparam int UNLOCK_KEY_LSB = 0;
	localparam logic [3:0] UNLOCK_PATTERN = 4'h9;
	localparam int LANE_SELECT_POS = 0;
	localparam int RESULT_CODING_POS = 0;
	localparam int REF_SOURCE_POS = 0;
	localparam int TRIM_MSB_POS = 0;
	localparam int RANGE_SELECT_POS = 1;
	localparam int INPUT_MODE_POS = 0;

endpackage

/* pkg/frame_if.sv */
// decoded frames and serial timing events between receiver and bank
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
	logic frame_stb;
	logic [3:0] frame_cmd;
	logic [7:0] frame_addr;
	logic [7:0] frame_data;
	logic cs_fall;
	logic cs_low;
	logic sclk_fall;

	modport rx (output frame_stb, frame_cmd, frame_addr, frame_data,
		cs_fall, cs_low, sclk_fall);
	modport bank (input frame_stb, frame_cmd, frame_addr, frame_data,
		cs_fall, cs_low, sclk_fall);
endinterface
`default_nettype wire

/* verilog/adc_config_bank.sv */
// configuration register bank of the dual converter with serial access
`timescale 1ns/1ps
`default_nettype none
module adc_config_bank
	import cfg_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// serial command pins
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SDI,
	// serial output lanes
	output logic SERIAL_OUT_FIRST,
	output logic SERIAL_OUT_FIRST_OE,
	output logic SERIAL_OUT_SECOND,
	output logic SERIAL_OUT_SECOND_OE,
	// power controls
	output logic CONVERTER_POWER_ON,
	output logic ANALOG_POWER_ON,
	output logic STANDBY_BIT,
	output logic FULL_POWERDOWN_BIT,
	// conversion setup
	output logic LANE_SELECT_BIT,
	output logic RESULT_CODING_BIT,
	output logic REFERENCE_SOURCE_BIT,
	output logic RANGE_SELECT_BIT,
	output logic INPUT_MODE_BIT,
	// reference trim codes
	output logic [8:0] REF_TRIM_CODE_FIRST,
	output logic [8:0] REF_TRIM_CODE_SECOND
);
	frame_if fif ();

	logic [NUM_REGS-1:0][7:0] regs_r;
	logic [NUM_REGS-1:0][7:0] regs_nxt;
	logic [7:0] readback_r;
	logic [7:0] readback_nxt;
	logic pending_r;
	logic pending_nxt;
	logic [7:0] out_shift_r;
	logic [7:0] out_shift_nxt;
	logic oe_first_r;
	logic oe_second_r;
	logic out_second_r;
	logic conv_on_r;
	logic analog_on_r;

	// ------------------------------------------------------------
	// serial receiver
	// ------------------------------------------------------------
	serial_frame_rx u_rx (
		.clk(MCLK),
		.rst_n(RESET_N),
		.cs_n_pin(CS_N),
		.sclk_pin(SCLK),
		.sdi_pin(SDI),
		.fr(fif.rx)
	);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// returns {hit, index}; unmapped offsets give no hit
	function automatic logic [4:0] reg_lookup(input logic [7:0] addr);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (REG_OFFSET[i] == addr) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// lookup of the frame address and the key state
	wire [4:0] lookup = reg_lookup(fif.frame_addr);
	wire hit = lookup[4];
	wire [3:0] idx = lookup[3:0];
	wire [7:0] cur_val = hit ? regs_r[idx] : 8'h00;
	wire unlocked = (regs_r[IDX_UNLOCK_KEY][UNLOCK_KEY_MSB:UNLOCK_KEY_LSB]
		== UNLOCK_PATTERN); // [RQ3]
	// power control is locked until the key holds the pattern
	wire allowed = hit & ((idx != IDX_POWER_CONTROL) | unlocked); // [RQ19]

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire is_write = fif.frame_cmd == CMD_WRITE;
	wire is_set = fif.frame_cmd == CMD_SET_MASKED;
	wire is_clear = fif.frame_cmd == CMD_CLEAR_MASKED;
	wire is_read = fif.frame_stb & (fif.frame_cmd == CMD_READ); // [RQ15]
	// every other code falls through as idle
	wire do_modify = fif.frame_stb & allowed & (is_write | is_set | is_clear);
	wire [7:0] mod_val = is_write ? fif.frame_data :
		is_set ? (cur_val | fif.frame_data) :
		(cur_val & ~fif.frame_data); // [RQ15] [RQ20]

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	// write mask keeps reserved bits at zero for all commands
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
		assign regs_nxt[g] = (do_modify && idx == 4'(g)) ?
			((mod_val & WRITE_MASK[g]) | (regs_r[g] & ~WRITE_MASK[g])) :
			regs_r[g]; // [RQ19] [RQ20]
	end

	// every register clears to zero on reset
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			regs_r <= {NUM_REGS{REG_RESET}}; // [RQ14]
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// ------------------------------------------------------------
	// readback path
	// ------------------------------------------------------------
	// a read arms the next frame; set wins over the frame-start clear
	assign readback_nxt = is_read ? cur_val : readback_r; // [RQ17]
	assign pending_nxt = is_read ? 1'b1 : fif.cs_fall ? 1'b0 : pending_r;
	// msb first; without a pending read the lane stays low
	assign out_shift_nxt = fif.cs_fall ? (pending_r ? readback_r : 8'h00) :
		(fif.sclk_fall & fif.cs_low) ? {out_shift_r[6:0], 1'b0} :
		out_shift_r; // [RQ17]

	// readback registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			readback_r <= 8'h00;
			pending_r <= 1'b0;
			out_shift_r <= 8'h00;
		end else begin
			readback_r <= readback_nxt;
			pending_r <= pending_nxt;
			out_shift_r <= out_shift_nxt;
		end
	end

	// lane drivers; second lane released in single-lane mode
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			oe_first_r <= 1'b0;
			oe_second_r <= 1'b0;
			out_second_r <= 1'b0;
		end else begin
			oe_first_r <= fif.cs_low;
			oe_second_r <= fif.cs_low &
				~regs_r[IDX_LANE_SELECT][LANE_SELECT_POS]; // [RQ4]
			out_second_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// power domains
	// ------------------------------------------------------------
	// full power-down dominates standby
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			conv_on_r <= 1'b1;
			analog_on_r <= 1'b1;
		end else begin
			conv_on_r <= ~(regs_r[IDX_POWER_CONTROL][STANDBY_POS] |
				regs_r[IDX_POWER_CONTROL][FULL_POWERDOWN_POS]); // [RQ1] [RQ2]
			analog_on_r <= ~regs_r[IDX_POWER_CONTROL][FULL_POWERDOWN_POS]; // [RQ2]
		end
	end

	// ------------------------------------------------------------
	// outputs, all taken from flip-flops
	// ------------------------------------------------------------
	assign SERIAL_OUT_FIRST = out_shift_r[7];
	assign SERIAL_OUT_FIRST_OE = oe_first_r;
	assign SERIAL_OUT_SECOND = out_second_r;
	assign SERIAL_OUT_SECOND_OE = oe_second_r;
	assign CONVERTER_POWER_ON = conv_on_r;
	assign ANALOG_POWER_ON = analog_on_r;
	assign STANDBY_BIT = regs_r[IDX_POWER_CONTROL][STANDBY_POS]; // [RQ1]
	assign FULL_POWERDOWN_BIT =
		regs_r[IDX_POWER_CONTROL][FULL_POWERDOWN_POS]; // [RQ2]
	assign LANE_SELECT_BIT = regs_r[IDX_LANE_SELECT][LANE_SELECT_POS]; // [RQ4]
	assign RESULT_CODING_BIT =
		regs_r[IDX_FORMAT_SELECT][RESULT_CODING_POS]; // [RQ5]
	assign REFERENCE_SOURCE_BIT =
		regs_r[IDX_REF_SOURCE][REF_SOURCE_POS]; // [RQ6]
	assign RANGE_SELECT_BIT =
		regs_r[IDX_INPUT_SETUP][RANGE_SELECT_POS]; // [RQ12]
	assign INPUT_MODE_BIT = regs_r[IDX_INPUT_SETUP][INPUT_MODE_POS]; // [RQ13]
	// nine-bit trims: high register bit 0 on top of the low byte
	assign REF_TRIM_CODE_FIRST = {regs_r[IDX_TRIM_FIRST_HIGH][TRIM_MSB_POS],
		regs_r[IDX_TRIM_FIRST_LOW]}; // [RQ7] [RQ8]
	assign REF_TRIM_CODE_SECOND = {regs_r[IDX_TRIM_SECOND_HIGH][TRIM_MSB_POS],
		regs_r[IDX_TRIM_SECOND_LOW]}; // [RQ10]

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_reset_zero: assert property (@(posedge MCLK) // [RQ14]
		$rose(RESET_N) |-> (regs_r == '0) && !pending_r)
		else $error("registers not zero after reset");

	a_reserved_zero: assert property (@(posedge MCLK) // [RQ19]
		disable iff (!RESET_N)
		((regs_r[IDX_POWER_CONTROL] & ~WRITE_MASK[IDX_POWER_CONTROL]) == 8'h00)
		&& ((regs_r[IDX_INPUT_SETUP] & ~WRITE_MASK[IDX_INPUT_SETUP]) == 8'h00)
		&& ((regs_r[IDX_TRIM_FIRST_HIGH] & 8'hFE) == 8'h00))
		else $error("reserved bit set");

	a_locked_power_hold: assert property (@(posedge MCLK) // [RQ3]
		disable iff (!RESET_N)
		fif.frame_stb && hit && idx == IDX_POWER_CONTROL && !unlocked
		|=> $stable(regs_r[IDX_POWER_CONTROL]))
		else $error("locked power control changed");

	a_unlocked_write: assert property (@(posedge MCLK) // [RQ3]
		disable iff (!RESET_N)
		fif.frame_stb && is_write && hit && idx == IDX_POWER_CONTROL
		&& unlocked |=> regs_r[IDX_POWER_CONTROL] ==
		($past(fif.frame_data) & 8'h06))
		else $error("unlocked power write lost");

	a_set_masked: assert property (@(posedge MCLK) // [RQ20]
		disable iff (!RESET_N)
		fif.frame_stb && is_set && hit && idx == IDX_INPUT_SETUP
		|=> regs_r[IDX_INPUT_SETUP] == (($past(regs_r[IDX_INPUT_SETUP])
		| $past(fif.frame_data)) & WRITE_MASK[IDX_INPUT_SETUP]))
		else $error("set masked wrong");

	a_clear_masked: assert property (@(posedge MCLK) // [RQ20]
		disable iff (!RESET_N)
		fif.frame_stb && is_clear && hit && idx == IDX_INPUT_SETUP
		|=> regs_r[IDX_INPUT_SETUP] ==
		($past(regs_r[IDX_INPUT_SETUP]) & ~$past(fif.frame_data)))
		else $error("clear masked wrong");

	a_idle_no_change: assert property (@(posedge MCLK) // [RQ15]
		disable iff (!RESET_N)
		fif.frame_stb && !is_write && !is_set && !is_clear
		|=> $stable(regs_r))
		else $error("idle or read changed a register");

	a_standby_power: assert property (@(posedge MCLK) // [RQ1]
		disable iff (!RESET_N)
		STANDBY_BIT && !FULL_POWERDOWN_BIT
		|=> !CONVERTER_POWER_ON && ANALOG_POWER_ON)
		else $error("standby power wrong");

	a_full_powerdown: assert property (@(posedge MCLK) // [RQ2]
		disable iff (!RESET_N)
		FULL_POWERDOWN_BIT |=> !CONVERTER_POWER_ON && !ANALOG_POWER_ON)
		else $error("full power-down not applied");

	a_readback_msb: assert property (@(posedge MCLK) // [RQ17]
		disable iff (!RESET_N)
		fif.cs_fall && pending_r
		|=> SERIAL_OUT_FIRST == $past(readback_r[7]) && SERIAL_OUT_FIRST_OE)
		else $error("readback msb missing");

	a_single_lane: assert property (@(posedge MCLK) // [RQ4]
		disable iff (!RESET_N)
		LANE_SELECT_BIT && fif.cs_low |=> !SERIAL_OUT_SECOND_OE)
		else $error("second lane driven in single-lane mode");
endmodule
`default_nettype wire

/* verilog/serial_frame_rx.sv */
// serial command receiver: pin synchronisers, bit counting, frame capture
`timescale 1ns/1ps
`default_nettype none
module serial_frame_rx
	import cfg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial pins
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic sdi_pin,
	// towards the register bank
	frame_if.rx fr
);
	logic [1:0] cs_sync_r;
	logic [1:0] sclk_sync_r;
	logic [1:0] sdi_sync_r;
	logic cs_prev_r;
	logic sclk_prev_r;
	logic [19:0] shift_r;
	logic [19:0] shift_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;

	// ------------------------------------------------------------
	// edge detection on the second synchroniser stage only
	// ------------------------------------------------------------
	wire cs_n_s = cs_sync_r[1];
	wire sclk_s = sclk_sync_r[1];
	wire cs_rise = cs_n_s & ~cs_prev_r;
	wire cs_fall_w = ~cs_n_s & cs_prev_r;
	wire sclk_rise = sclk_s & ~sclk_prev_r & ~cs_n_s;
	wire sclk_fall_w = ~sclk_s & sclk_prev_r & ~cs_n_s;
	// count saturates: only the last 20 bits stay in the shifter
	wire cnt_full = (cnt_r == FRAME_BITS);
	wire frame_ok = cs_rise & cnt_full; // [RQ16]

	// next shift and count values
	assign shift_nxt = sclk_rise ? {shift_r[18:0], sdi_sync_r[1]} : shift_r;
	assign cnt_nxt = cs_fall_w ? 5'h00 :
		(sclk_rise & ~cnt_full) ? cnt_r + 5'h01 : cnt_r; // [RQ16]

	// two-stage synchronisers; chip select idles high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync_r <= 2'h3;
			sclk_sync_r <= 2'h0;
			sdi_sync_r <= 2'h0;
			cs_prev_r <= 1'b1;
			sclk_prev_r <= 1'b0;
		end else begin
			cs_sync_r <= {cs_sync_r[0], cs_n_pin};
			sclk_sync_r <= {sclk_sync_r[0], sclk_pin};
			sdi_sync_r <= {sdi_sync_r[0], sdi_pin};
			cs_prev_r <= cs_n_s;
			sclk_prev_r <= sclk_s;
		end
	end

	// bit capture on serial clock rise, frame released on cs rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= 20'h00000;
			cnt_r <= 5'h00;
			fr.frame_stb <= 1'b0;
			fr.frame_cmd <= CMD_IDLE;
			fr.frame_addr <= 8'h00;
			fr.frame_data <= 8'h00;
		end else begin
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			fr.frame_stb <= frame_ok;
			if (frame_ok) begin
				fr.frame_cmd <= shift_r[CMD_MSB:CMD_LSB];
				fr.frame_addr <= shift_r[ADDR_MSB:ADDR_LSB];
				fr.frame_data <= shift_r[DATA_MSB:DATA_LSB];
			end
		end
	end

	// timing events for the readback shifter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fr.cs_fall <= 1'b0;
			fr.cs_low <= 1'b0;
			fr.sclk_fall <= 1'b0;
		end else begin
			fr.cs_fall <= cs_fall_w;
			fr.cs_low <= ~cs_n_s;
			fr.sclk_fall <= sclk_fall_w;
		end
	end
endmodule
`default_nettype wire
